// ==== pkg/lal_pkg.sv ====
// Shared constants for the latch and lookup table block.
// Assumes one 25 MHz clock; control sources arrive as unsigned words.
package lal_pkg;

    // ========================================================
    // Widths and sizes
    localparam int DW      = 16;  // Control value width
    localparam int NPT     = 11;  // Points 0..10, i.e. ten slopes
    localparam int NSRC    = 8;   // Selectable control sources
    localparam int SIW     = 3;   // Source index width
    localparam int PW      = 7;   // Percent field width

    // ========================================================
    // Encodings
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_RAMP   = 2'h1;
    localparam logic [1:0] RESP_JUMP   = 2'h2;
    localparam logic       MODE_DATA   = 1'h0;
    localparam logic       MODE_TIME   = 1'h1;
    localparam logic       SRC_UNUSED  = 1'h0;
    localparam logic [PW-1:0] PCT_FULL = 7'h64;  // 100 percent

    // ========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_TIME_NS    = 1000000;
    localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;

    // Sequencer states for time response
    typedef enum logic [1:0] {TM_STOP, TM_RUN, TM_HOLD} lal_tm_e;

    // ========================================================
    // Source selection: an unused source reads as zero
    function automatic logic [DW-1:0] lal_pick(
        input logic                     used,
        input logic [SIW-1:0]           idx,
        input logic [NSRC-1:0][DW-1:0]  vals
    );
        lal_pick = (used == SRC_UNUSED) ? {DW{1'b0}} : vals[idx];
    endfunction : lal_pick

endpackage : lal_pkg

// ==== design/lal_latch.sv ====
// Set/reset latch with threshold qualification of both inputs.
// Inputs come from same-clock function blocks; no synchronisers.
`timescale 1ns/1ps
module lal_latch
    import lal_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    // Set source value, range and thresholds
    input  wire logic [DW-1:0] set_val_i,
    input  wire logic [DW-1:0] set_rng_min_i,
    input  wire logic [DW-1:0] set_rng_max_i,
    input  wire logic [PW-1:0] set_thr_lo_i,
    input  wire logic [PW-1:0] set_thr_hi_i,
    // Reset source value, range and thresholds
    input  wire logic [DW-1:0] rst_val_i,
    input  wire logic [DW-1:0] rst_rng_min_i,
    input  wire logic [DW-1:0] rst_rng_max_i,
    input  wire logic [PW-1:0] rst_thr_lo_i,
    input  wire logic [PW-1:0] rst_thr_hi_i,
    // Results
    output logic               set_on_o,
    output logic               rst_on_o,
    output logic               latch_o
);

    // ========================================================
    // Qualification
    // Level at pct percent of the range; saturates if range inverted
    function automatic logic [DW-1:0] lal_level(
        input logic [DW-1:0] rmin,
        input logic [DW-1:0] rmax,
        input logic [PW-1:0] pct
    );
        logic [DW+PW-1:0] span;
        span = 23'((rmax > rmin) ? rmax - rmin : {DW{1'b0}}) * 23'(pct);
        lal_level = rmin + DW'(span / 23'(PCT_FULL));
    endfunction : lal_level

    // Hysteresis: ON at or above high level, OFF at or below low level, else hold
    function automatic logic lal_qual(
        input logic          prev,
        input logic [DW-1:0] v,
        input logic [DW-1:0] lo,
        input logic [DW-1:0] hi
    );
        if (v >= hi) begin
            lal_qual = 1'b1;
        end else if (v <= lo) begin
            lal_qual = 1'b0;
        end else begin
            lal_qual = prev;
        end
    endfunction : lal_qual

    logic set_on;
    logic rst_on;
    logic latch;
    logic next_set_on;
    logic next_rst_on;
    logic next_latch;

    // Next qualified inputs and latch state
    always_comb begin
        next_set_on = lal_qual(set_on, set_val_i,
            lal_level(set_rng_min_i, set_rng_max_i, set_thr_lo_i),
            lal_level(set_rng_min_i, set_rng_max_i, set_thr_hi_i));
        next_rst_on = lal_qual(rst_on, rst_val_i,
            lal_level(rst_rng_min_i, rst_rng_max_i, rst_thr_lo_i),
            lal_level(rst_rng_min_i, rst_rng_max_i, rst_thr_hi_i));
        // Reset has precedence; set then holds until reset
        if (rst_on) begin
            next_latch = 1'b0;
        end else if (set_on) begin
            next_latch = 1'b1;
        end else begin
            next_latch = latch;
        end
    end

    // Output starts OFF after reset
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            set_on <= 1'b0;
            rst_on <= 1'b0;
            latch  <= 1'b0;
        end else begin
            set_on <= next_set_on;
            rst_on <= next_rst_on;
            latch  <= next_latch;
        end
    end

    assign set_on_o = set_on;
    assign rst_on_o = rst_on;
    assign latch_o  = latch;

endmodule : lal_latch

// ==== design/lal_top.sv ====
// Latch and piecewise lookup table control function blocks.
// Sources come from same-clock logic; configuration is held stable
// by the configuring party, updated a word at a time.
//
// Functional notes
// - Reset input ON forces latch OFF
// - Latch starts OFF, sets, holds until reset
// - Inputs qualified by percent min/max thresholds
// - Table has eleven points, ten slopes
// - Mode zero data, one time response
// - Data mode compares X against selected source
// - Time mode: X is milliseconds, source enables
// - Auto-repeat restarts time sequence after last point
// - Point response: 0 ignore, 1 ramp, 2 jump
// - Ramp interpolates linearly between Y values
// - Jump segment outputs current point Y exactly
// - Point zero response fixed as jump
// - Ignore drops that point and all higher
// - X points forced ascending within input range
// - Output range is min/max of used Y
`timescale 1ns/1ps
module lal_top
    import lal_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES  // Clocks per millisecond
)(
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      arst_n_i,
    // Control source values from other function blocks
    input  wire logic [NSRC-1:0][DW-1:0]   src_val_i,
    // Latch set source selection and thresholds
    input  wire logic                      set_src_used_i,
    input  wire logic [SIW-1:0]            set_src_idx_i,
    input  wire logic [DW-1:0]             set_rng_min_i,
    input  wire logic [DW-1:0]             set_rng_max_i,
    input  wire logic [PW-1:0]             set_thr_lo_i,
    input  wire logic [PW-1:0]             set_thr_hi_i,
    // Latch reset source selection and thresholds
    input  wire logic                      rst_src_used_i,
    input  wire logic [SIW-1:0]            rst_src_idx_i,
    input  wire logic [DW-1:0]             rst_rng_min_i,
    input  wire logic [DW-1:0]             rst_rng_max_i,
    input  wire logic [PW-1:0]             rst_thr_lo_i,
    input  wire logic [PW-1:0]             rst_thr_hi_i,
    // Table configuration
    input  wire logic                      tbl_mode_i,
    input  wire logic                      tbl_repeat_i,
    input  wire logic                      tbl_src_used_i,
    input  wire logic [SIW-1:0]            tbl_src_idx_i,
    input  wire logic [DW-1:0]             tbl_in_min_i,
    input  wire logic [DW-1:0]             tbl_in_max_i,
    input  wire logic [NPT-1:0][DW-1:0]    tbl_x_i,
    input  wire logic [NPT-1:0][DW-1:0]    tbl_y_i,
    input  wire logic [NPT-1:0][1:0]       tbl_resp_i,
    // Latch results
    output logic                           latch_out_o,
    output logic                           set_on_o,
    output logic                           rst_on_o,
    // Table results
    output logic signed [DW-1:0]           tbl_out_o,
    output logic signed [DW-1:0]           tbl_out_min_o,
    output logic signed [DW-1:0]           tbl_out_max_o,
    output logic [DW-1:0]                  tbl_elapsed_o,
    output logic                           tbl_x_fixed_o
);

    localparam logic [DW-1:0] TICK_LAST = DW'(TICK_CYCLES - 1);

    // ========================================================
    // Helpers
    function automatic logic [DW-1:0] lal_clamp(
        input logic [DW-1:0] v,
        input logic [DW-1:0] lo,
        input logic [DW-1:0] hi
    );
        if (v < lo) begin
            lal_clamp = lo;
        end else if (v > hi) begin
            lal_clamp = hi;
        end else begin
            lal_clamp = v;
        end
    endfunction : lal_clamp

    // Linear interpolation; wide product keeps full precision
    function automatic logic signed [DW-1:0] lal_interp(
        input logic signed [DW-1:0] ya,
        input logic signed [DW-1:0] yb,
        input logic [DW-1:0]        xa,
        input logic [DW-1:0]        xb,
        input logic [DW-1:0]        v
    );
        logic signed [DW:0]      dy;
        logic [DW-1:0]           dv;
        logic [DW-1:0]           dx;
        logic signed [2*DW+1:0]  prod;
        logic signed [2*DW+1:0]  quot;
        dy = {yb[DW-1], yb} - {ya[DW-1], ya};
        dv = v - xa;
        dx = xb - xa;
        prod = $signed({{(DW+1){dy[DW]}}, dy})
             * $signed({{(DW+2){1'b0}}, dv});
        if (dx == {DW{1'b0}}) begin
            quot = {(2*DW+2){1'b0}};
        end else begin
            quot = prod / $signed({{(DW+2){1'b0}}, dx});
        end
        lal_interp = ya + $signed(quot[DW-1:0]);
    endfunction : lal_interp

    // ========================================================
    // Latch
    lal_latch u_latch (
        .clk_i         (clk_i),
        .arst_n_i      (arst_n_i),
        .set_val_i     (lal_pick(set_src_used_i, set_src_idx_i, src_val_i)),
        .set_rng_min_i (set_rng_min_i),
        .set_rng_max_i (set_rng_max_i),
        .set_thr_lo_i  (set_thr_lo_i),
        .set_thr_hi_i  (set_thr_hi_i),
        .rst_val_i     (lal_pick(rst_src_used_i, rst_src_idx_i, src_val_i)),
        .rst_rng_min_i (rst_rng_min_i),
        .rst_rng_max_i (rst_rng_max_i),
        .rst_thr_lo_i  (rst_thr_lo_i),
        .rst_thr_hi_i  (rst_thr_hi_i),
        .set_on_o      (set_on_o),
        .rst_on_o      (rst_on_o),
        .latch_o       (latch_out_o)
    );

    // ========================================================
    // Point table preparation
    logic [NPT-1:0][DW-1:0] x_eff;
    logic [NPT-1:0][1:0]    resp_eff;
    logic [3:0]             last;
    logic                   x_bad;
    logic                   stop;
    logic [DW-1:0]          src_sel;

    // Effective points, last used index and X clamping
    always_comb begin
        x_bad = 1'b0;
        stop  = 1'b0;
        last  = 4'h0;
        for (int i = 0; i < NPT; i++) begin
            if (i == 0) begin
                resp_eff[i] = RESP_JUMP;
                x_eff[i] = lal_clamp(tbl_x_i[i], tbl_in_min_i,
                                     tbl_in_max_i);
            end else begin
                resp_eff[i] = tbl_resp_i[i];
                // Non-decreasing: never below the previous point
                x_eff[i] = lal_clamp(tbl_x_i[i], x_eff[i-1],
                                     tbl_in_max_i);
            end
            if (x_eff[i] != tbl_x_i[i]) begin
                x_bad = 1'b1;
            end
            // First ignored point ends the table
            if (i > 0 && !stop) begin
                if (resp_eff[i] == RESP_IGNORE) begin
                    stop = 1'b1;
                end else begin
                    last = 4'(i);
                end
            end
        end
        src_sel = lal_pick(tbl_src_used_i, tbl_src_idx_i, src_val_i);
    end

    // ========================================================
    // Time response sequencer
    lal_tm_e       tm_state;
    lal_tm_e       next_tm_state;
    logic [DW-1:0] tick_cnt;
    logic [DW-1:0] next_tick_cnt;
    logic [DW-1:0] ms_cnt;
    logic [DW-1:0] next_ms_cnt;
    logic          tbl_en;

    // Source acts only as a digital enable in time mode
    assign tbl_en = (src_sel != {DW{1'b0}});

    // Millisecond progression, restart and hold
    always_comb begin
        next_tm_state = tm_state;
        next_tick_cnt = tick_cnt;
        next_ms_cnt   = ms_cnt;
        if (tbl_mode_i != MODE_TIME || !tbl_en) begin
            next_tm_state = TM_STOP;
            next_tick_cnt = {DW{1'b0}};
            next_ms_cnt   = {DW{1'b0}};
        end else begin
            case (tm_state)
                TM_STOP: begin
                    next_tm_state = TM_RUN;
                    next_tick_cnt = {DW{1'b0}};
                    next_ms_cnt   = {DW{1'b0}};
                end
                TM_RUN: begin
                    if (tick_cnt >= TICK_LAST) begin
                        next_tick_cnt = {DW{1'b0}};
                        if (ms_cnt < x_eff[last]) begin
                            next_ms_cnt = ms_cnt + 16'h0001;
                        end else if (tbl_repeat_i) begin
                            next_ms_cnt = {DW{1'b0}};
                        end else begin
                            next_tm_state = TM_HOLD;
                        end
                    end else begin
                        next_tick_cnt = tick_cnt + 16'h0001;
                    end
                end
                TM_HOLD: begin
                    // A later repeat enable or longer table resumes
                    if (tbl_repeat_i || ms_cnt < x_eff[last]) begin
                        next_tm_state = TM_RUN;
                    end
                end
                default: begin
                    next_tm_state = TM_STOP;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tm_state <= TM_STOP;
            tick_cnt <= {DW{1'b0}};
            ms_cnt   <= {DW{1'b0}};
        end else begin
            tm_state <= next_tm_state;
            tick_cnt <= next_tick_cnt;
            ms_cnt   <= next_ms_cnt;
        end
    end

    // ========================================================
    // Evaluation
    logic [DW-1:0]          x_in;
    logic [3:0]             seg;
    logic                   found;
    logic signed [DW-1:0]   next_out;
    logic signed [DW-1:0]   next_min;
    logic signed [DW-1:0]   next_max;

    // Segment search and output; limits cover used points only
    always_comb begin
        if (tbl_mode_i == MODE_TIME) begin
            x_in = ms_cnt;
        end else begin
            x_in = lal_clamp(src_sel, tbl_in_min_i, tbl_in_max_i);
        end
        seg   = 4'h0;
        found = 1'b0;
        next_min = $signed(tbl_y_i[0]);
        next_max = $signed(tbl_y_i[0]);
        for (int i = 1; i < NPT; i++) begin
            if (4'(i) <= last) begin
                if (!found && x_in > x_eff[i-1]
                    && x_in <= x_eff[i]) begin
                    seg   = 4'(i);
                    found = 1'b1;
                end
                if ($signed(tbl_y_i[i]) < next_min) begin
                    next_min = $signed(tbl_y_i[i]);
                end
                if ($signed(tbl_y_i[i]) > next_max) begin
                    next_max = $signed(tbl_y_i[i]);
                end
            end
        end
        if (!found) begin
            // Below X0 gives Y0, beyond the last point gives its Y
            if (x_in > x_eff[last]) begin
                next_out = $signed(tbl_y_i[last]);
            end else begin
                next_out = $signed(tbl_y_i[0]);
            end
        end else if (resp_eff[seg] == RESP_RAMP) begin
            next_out = lal_interp($signed(tbl_y_i[seg-4'h1]),
                                  $signed(tbl_y_i[seg]),
                                  x_eff[seg-4'h1], x_eff[seg],
                                  x_in);
        end else begin
            next_out = $signed(tbl_y_i[seg]);
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tbl_out_o     <= {DW{1'b0}};
            tbl_out_min_o <= {DW{1'b0}};
            tbl_out_max_o <= {DW{1'b0}};
            tbl_elapsed_o <= {DW{1'b0}};
            tbl_x_fixed_o <= 1'b0;
        end else begin
            tbl_out_o     <= next_out;
            tbl_out_min_o <= next_min;
            tbl_out_max_o <= next_max;
            tbl_elapsed_o <= ms_cnt;
            tbl_x_fixed_o <= x_bad;
        end
    end

endmodule : lal_top

// ==== bench/lal_src_model.sv ====
// Model of the function blocks that feed the control sources.
// Assumes same-clock producers that update on the rising edge.
`timescale 1ns/1ps
module lal_src_model
    import lal_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    arst_n_i,
    // Commanded values and values seen by the block
    input  wire logic [NSRC-1:0][DW-1:0] cmd_i,
    output logic      [NSRC-1:0][DW-1:0] src_val_o
);
    // Registered like a real producer, so a change lands one edge late
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            src_val_o <= '0;
        end else begin
            src_val_o <= cmd_i;
        end
    end
endmodule : lal_src_model

// ==== bench/lal_top_properties.sv ====
// Checker for the latch and lookup table block.
// Bound to lal_top; sees its ports only, one clock domain.
`timescale 1ns/1ps
module lal_top_properties
    import lal_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES
)(
    // Watched ports
    input wire logic                   clk_i,
    input wire logic                   arst_n_i,
    input wire logic [NPT-1:0][DW-1:0] tbl_y_i,
    input wire logic [NPT-1:0][1:0]    tbl_resp_i,
    input wire logic                   tbl_mode_i,
    input wire logic                   latch_out_o,
    input wire logic                   set_on_o,
    input wire logic                   rst_on_o,
    input wire logic signed [DW-1:0]   tbl_out_o,
    input wire logic signed [DW-1:0]   tbl_out_min_o,
    input wire logic signed [DW-1:0]   tbl_out_max_o,
    input wire logic [DW-1:0]          tbl_elapsed_o,
    input wire logic                   tbl_x_fixed_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // ========================================================
    // Clocks since elapsed time last moved
    logic [15:0]   cnt;
    logic [15:0]   next_cnt;
    logic [DW-1:0] prev;
    logic [DW-1:0] next_prev;
    always_comb begin
        next_prev = tbl_elapsed_o;
        next_cnt  = (tbl_elapsed_o != prev) ? 16'h0 : cnt + 16'h1;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt  <= 16'h0;
            prev <= 16'h0;
        end else begin
            cnt  <= next_cnt;
            prev <= next_prev;
        end
    end

    // ========================================================
    // Latch
    a_reset_wins: assert property (rst_on_o |=> !latch_out_o)
        else $error("latch on under reset");
    a_set_latches: assert property (set_on_o && !rst_on_o
        |=> latch_out_o)
        else $error("latch missed set");
    a_latch_holds: assert property (!set_on_o && !rst_on_o
        |=> $stable(latch_out_o))
        else $error("latch moved while idle");
    a_rise_cause: assert property ($rose(latch_out_o)
        |-> $past(set_on_o) && !$past(rst_on_o))
        else $error("latch rose without set");

    // ========================================================
    // Table; the range check skips a cycle after Y or response edits
    a_out_bounded: assert property ($stable(tbl_y_i)
        && $stable(tbl_resp_i)
        |=> tbl_out_o >= tbl_out_min_o && tbl_out_o <= tbl_out_max_o)
        else $error("table output outside range");
    a_data_no_time: assert property (tbl_mode_i == MODE_DATA
        ##1 tbl_mode_i == MODE_DATA |=> tbl_elapsed_o == 16'h0)
        else $error("time ran in data mode");
    a_time_steps: assert property (tbl_elapsed_o != prev
        |-> tbl_elapsed_o == prev + 16'h1 || tbl_elapsed_o == 16'h0)
        else $error("elapsed time jumped");
    a_tick_spacing: assert property (tbl_elapsed_o == prev + 16'h1
        && prev != 16'h0 |-> cnt == TICK_CYCLES - 1)
        else $error("millisecond tick spacing wrong");

    c_latched: cover property ($rose(latch_out_o));
    c_clamped: cover property (tbl_x_fixed_o);
    c_wrapped: cover property (prev == 16'hA && tbl_elapsed_o == 16'h0);
endmodule : lal_top_properties

bind lal_top lal_top_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);

// ==== bench/test_lal_top.sv ====
// Self-checking bench for the latch and lookup table block.
// Sources pass through lal_src_model; config ports are driven directly.
`timescale 1ns/1ps
module test_lal_top
    import lal_pkg::*;
;
    localparam int TICK = 4;  // Short millisecond keeps the run brief
    logic                    clk_i          = 1'b0;
    logic                    arst_n_i       = 1'b0;
    logic [NSRC-1:0][DW-1:0] cmd            = '0;
    logic [NSRC-1:0][DW-1:0] src_val_i;
    logic                    set_src_used_i = 1'b1;
    logic                    rst_src_used_i = 1'b1;
    logic                    tbl_src_used_i = 1'b1;
    logic [SIW-1:0]          set_src_idx_i  = 3'h1;
    logic [SIW-1:0]          rst_src_idx_i  = 3'h2;
    logic [SIW-1:0]          tbl_src_idx_i  = 3'h0;
    logic [DW-1:0]           set_rng_min_i  = 16'h0000;
    logic [DW-1:0]           rst_rng_min_i  = 16'h0000;
    logic [DW-1:0]           tbl_in_min_i   = 16'h0000;
    logic [DW-1:0]           set_rng_max_i  = 16'h03E8;
    logic [DW-1:0]           rst_rng_max_i  = 16'h03E8;
    logic [DW-1:0]           tbl_in_max_i   = 16'h03E8;
    logic [PW-1:0]           set_thr_lo_i   = 7'h14;
    logic [PW-1:0]           rst_thr_lo_i   = 7'h14;
    logic [PW-1:0]           set_thr_hi_i   = 7'h50;
    logic [PW-1:0]           rst_thr_hi_i   = 7'h50;
    logic                    tbl_mode_i     = MODE_DATA;
    logic                    tbl_repeat_i   = 1'b0;
    logic [NPT-1:0][DW-1:0]  tbl_x_i        = '0;
    logic [NPT-1:0][DW-1:0]  tbl_y_i        = '0;
    logic [NPT-1:0][1:0]     tbl_resp_i     = '0;
    logic                    latch_out_o, set_on_o, rst_on_o, tbl_x_fixed_o;
    logic signed [DW-1:0]    tbl_out_o, tbl_out_min_o, tbl_out_max_o;
    logic [DW-1:0]           tbl_elapsed_o;
    int                      n_fail         = 0;
    int                      n_tests        = 0;

    always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

    lal_src_model u_src (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .cmd_i     (cmd),
        .src_val_o (src_val_i)
    );
    lal_top #(.TICK_CYCLES(TICK)) u_dut (.*);

    // ========================================================
    // Helpers; sampling 1 ns after an edge avoids edge races
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_n
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk1
    task automatic chk16(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk16
    // Source, model and result registers need four edges to settle
    task automatic src(input int i, input logic [DW-1:0] v);
        @(posedge clk_i);
        cmd[i] <= v;
        wait_n(4);
    endtask : src
    // Bounded wait for a given elapsed time
    task automatic wait_ms(input logic [DW-1:0] v);
        for (int k = 0; k < 200 && tbl_elapsed_o !== v; k++) wait_n(1);
        chk16(tbl_elapsed_o, v);
    endtask : wait_ms
    // X steps by step, Y by 30 with Y10 at -100, jumps up to point 4
    task automatic load_table(input logic [DW-1:0] step);
        @(posedge clk_i);
        for (int i = NPT - 1; i >= 0; i--) begin
            tbl_x_i[i]    <= DW'(i) * step;
            tbl_y_i[i]    <= (i == 10) ? 16'hFF9C : DW'(i * 30);
            tbl_resp_i[i] <= (i == 0) ? RESP_IGNORE :
                             (i < 5) ? RESP_JUMP : RESP_RAMP;
        end
        wait_n(3);
    endtask : load_table

    // ========================================================
    // Scenarios
    task automatic test_latch;
        src(1, 16'h0384);
        chk1(set_on_o, 1'b1);
        chk1(latch_out_o, 1'b1);
        src(1, 16'h01F4);
        chk1(set_on_o, 1'b1);
        src(1, 16'h0064);
        chk1(set_on_o, 1'b0);
        chk1(latch_out_o, 1'b1);
        src(2, 16'h0352);
        chk1(latch_out_o, 1'b0);
        src(1, 16'h0384);
        chk1(latch_out_o, 1'b0);
        src(2, 16'h00C8);
        chk1(rst_on_o, 1'b0);
        chk1(latch_out_o, 1'b1);
        $display("test_latch done");
    endtask : test_latch

    // Threshold boundaries with offset range, then unused reset source
    task automatic test_latch_edge;
        @(posedge clk_i);
        set_thr_hi_i  <= 7'h5A;
        rst_rng_min_i <= 16'h03E8;
        rst_rng_max_i <= 16'h07D0;
        rst_thr_lo_i  <= 7'h0A;
        rst_thr_hi_i  <= 7'h3C;
        src(1, 16'h0000);
        src(1, 16'h0383);
        chk1(set_on_o, 1'b0);
        src(1, 16'h0384);
        chk1(set_on_o, 1'b1);
        src(2, 16'h063F);
        chk1(rst_on_o, 1'b0);
        src(2, 16'h0640);
        chk1(rst_on_o, 1'b1);
        chk1(latch_out_o, 1'b0);
        @(posedge clk_i);
        rst_src_used_i <= 1'b0;
        wait_n(4);
        chk1(latch_out_o, 1'b1);
        $display("test_latch_edge done");
    endtask : test_latch_edge

    task automatic test_data;
        logic [DW-1:0] xs [6] = '{16'h0000, 16'h0064, 16'h0096,
                                  16'h01C2, 16'h03A5, 16'h04B0};
        logic [DW-1:0] ys [6] = '{16'h0000, 16'h001E, 16'h003C,
                                  16'h0087, 16'h0094, 16'hFF9C};
        load_table(16'h0064);
        @(posedge clk_i);
        tbl_repeat_i <= 1'b1;          // Must not matter in data mode
        for (int i = 0; i < 6; i++) begin
            src(0, xs[i]);
            chk16(tbl_out_o, ys[i]);
        end
        chk16(tbl_out_min_o, 16'hFF9C);
        chk16(tbl_out_max_o, 16'h010E);
        @(posedge clk_i);
        tbl_resp_i[6] <= RESP_IGNORE;
        src(0, 16'h0320);
        chk16(tbl_out_o, 16'h0096);
        chk16(tbl_out_max_o, 16'h0096);
        chk16(tbl_out_min_o, 16'h0000);
        @(posedge clk_i);
        tbl_in_max_i <= 16'h01F4;
        wait_n(3);
        chk1(tbl_x_fixed_o, 1'b1);
        chk16(tbl_out_o, 16'h0096);
        @(posedge clk_i);
        tbl_in_max_i <= 16'h03E8;
        wait_n(3);
        chk1(tbl_x_fixed_o, 1'b0);
        $display("test_data done");
    endtask : test_data

    task automatic test_time;
        load_table(16'h0001);
        @(posedge clk_i);
        tbl_mode_i    <= MODE_TIME;
        tbl_repeat_i  <= 1'b0;
        tbl_src_idx_i <= 3'h3;
        cmd[3]        <= 16'h0001;
        wait_ms(16'h0005);
        chk16(tbl_out_o, 16'h0096);
        wait_ms(16'h000A);
        wait_n(3 * TICK);
        chk16(tbl_elapsed_o, 16'h000A);
        chk16(tbl_out_o, 16'hFF9C);
        @(posedge clk_i);
        tbl_repeat_i   <= 1'b1;
        wait_ms(16'h0000);
        wait_ms(16'h0001);
        @(posedge clk_i);
        tbl_src_used_i <= 1'b0;
        wait_n(3);
        chk16(tbl_elapsed_o, 16'h0000);
        chk16(tbl_out_o, 16'h0000);
        @(posedge clk_i);
        tbl_src_used_i <= 1'b1;
        wait_ms(16'h000A);
        $display("test_time done");
    endtask : test_time

    task automatic report_and_stop;
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        wait_n(2);
        chk1(latch_out_o, 1'b0);
        test_latch;
        test_latch_edge;
        test_data;
        test_time;
        report_and_stop;
    end

    // Watchdog, far beyond the roughly 255 cycles the tests take
    initial begin
        #(CLK_PERIOD_NS * 5000);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        report_and_stop;
    end
endmodule : test_lal_top
